// File: src/bpsr_pkg.sv
// Package: offsets, field positions and reset values for the power-state registers
package bpsr_pkg;
    // Configuration byte offsets
    localparam logic [7:0] PCS_OFFSET = 8'h4C;
    localparam logic [7:0] BSE_OFFSET = 8'h4E;
    localparam logic [7:0] CAP_OFFSET = 8'h4A;

    // Power control/status field positions
    localparam int PCS_STATE_LSB = 0;
    localparam int PCS_KEPT_BIT = 3;
    localparam int PCS_SCRATCH_BIT = 8;
    localparam int PCS_WAKE_STAT_BIT = 15;

    // Bridge support extension field positions
    localparam int BSE_CLK_STOP_BIT = 7;
    localparam int BSE_BUS_COND_BIT = 6;

    // Reset values
    localparam logic [1:0] STATE_RESET = 2'h0;
    localparam logic SCRATCH_RESET = 1'b0;
    localparam logic [15:0] PCS_RESET = 16'h0008;
    localparam logic [7:0] BSE_RESET = 8'h40;

    // Revision codes
    localparam logic [2:0] REV_1_1 = 3'h2;
    localparam logic [2:0] REV_1_2 = 3'h3;

    // Power state codes
    typedef enum logic [1:0] {
        BPSR_D0 = 2'b00,
        BPSR_D1 = 2'b01,
        BPSR_D2 = 2'b10,
        BPSR_D3HOT = 2'b11
    } bpsr_pstate_t;
endpackage

// File: src/bpsr_sync.sv
// Two-flop synchroniser for configuration straps
`timescale 1ns/1ps
module bpsr_sync (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Data
    input wire logic i_async,
    output logic o_sync
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } bpsr_sync_t;

    bpsr_sync_t sync_reg;
    bpsr_sync_t sync_next;

    always_comb begin
        sync_next = sync_reg;
        sync_next.stage1 = i_async;
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg.stage2;
endmodule

// File: src/bpsr_regs.sv
// Power control/status and bridge support extension configuration registers
`timescale 1ns/1ps

// Summary of operation
// [R1] Writable 2-bit power state, resets to D0
// [R2] Leaving D3hot causes no reset, keeps context
// [R3] Context-kept bit follows revision select
// [R4] Scratch wake enable, storage only, resets 0
// [R5] Wake status bit always reads 0
// [R6] Measurement scale and select read zero
// [R7] Bits 7:4 and 2 reserved, read zero
// [R8] Extension bit 7 mirrors clock stop config
// [R9] Stop secondary clocks in D3 if flagged
// [R10] Extension bit 6 fixed 1, bus B2
// [R11] Extension bits 5:0 reserved, read zero
// [R12] Revision select picks revision code 010/011
// [R13] Writes to read-only bits are ignored
module bpsr_regs (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Configuration access
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [1:0] i_cfg_be,
    input wire logic [15:0] i_cfg_wdata,
    output logic [15:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // General control straps
    input wire logic i_pm_revision_select,
    input wire logic i_secondary_clock_stop_config,
    // Power state outputs
    output logic [1:0] o_device_power_state_field,
    output logic o_wake_event_scratch_enable,
    output logic [2:0] o_pm_revision_code,
    output logic o_secondary_clock_run
);
    typedef struct packed {
        logic [1:0] pstate;
        logic scratch;
        logic [15:0] rdata;
        logic rvalid;
        logic [2:0] rev_code;
        logic clk_run;
    } bpsr_state_t;

    bpsr_state_t st_reg;
    bpsr_state_t st_next;
    logic rev_sel;
    logic clk_stop_cfg;

    bpsr_sync u_sync_rev (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_async(i_pm_revision_select),
        .o_sync(rev_sel)
    );

    bpsr_sync u_sync_stop (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_async(i_secondary_clock_stop_config),
        .o_sync(clk_stop_cfg)
    );

    localparam int PCS_IDX_STATE = bpsr_pkg::PCS_STATE_LSB;

    // Composes power control/status read value
    function automatic logic [15:0] pcs_value(input logic [1:0] ps, input logic scr,
                                              input logic sel);
        logic [15:0] v;
        v = 16'h0000; // R5 R6 R7
        v[PCS_IDX_STATE +: 2] = ps;
        v[bpsr_pkg::PCS_KEPT_BIT] = sel; // R3
        v[bpsr_pkg::PCS_SCRATCH_BIT] = scr;
        v[bpsr_pkg::PCS_WAKE_STAT_BIT] = 1'b0; // R5
        return v;
    endfunction

    // Composes bridge support extension read value
    function automatic logic [7:0] bse_value(input logic stop);
        logic [7:0] v;
        v = 8'h00; // R11
        v[bpsr_pkg::BSE_CLK_STOP_BIT] = stop; // R8
        v[bpsr_pkg::BSE_BUS_COND_BIT] = 1'b1; // R10
        return v;
    endfunction

    always_comb begin
        // Context held; D3hot to D0 rewrites only the state field
        st_next = st_reg; // R2
        st_next.rvalid = i_cfg_rd;
        st_next.rdata = 16'h0000;
        // Only state and scratch bits take writes
        if (i_cfg_wr && i_cfg_addr == bpsr_pkg::PCS_OFFSET) begin // R13
            if (i_cfg_be[0]) begin
                st_next.pstate = i_cfg_wdata[PCS_IDX_STATE +: 2]; // R1
            end
            if (i_cfg_be[1]) begin
                st_next.scratch = i_cfg_wdata[bpsr_pkg::PCS_SCRATCH_BIT]; // R4
            end
        end
        if (i_cfg_rd) begin
            if (i_cfg_addr == bpsr_pkg::PCS_OFFSET) begin
                st_next.rdata = pcs_value(st_reg.pstate, st_reg.scratch, rev_sel);
            end else if (i_cfg_addr == bpsr_pkg::BSE_OFFSET) begin
                st_next.rdata = {8'h00, bse_value(clk_stop_cfg)};
            end else if (i_cfg_addr == bpsr_pkg::CAP_OFFSET) begin
                st_next.rdata = {13'h0000, rev_sel ? bpsr_pkg::REV_1_2 : bpsr_pkg::REV_1_1};
            end
        end
        st_next.rev_code = rev_sel ? bpsr_pkg::REV_1_2 : bpsr_pkg::REV_1_1; // R12
        st_next.clk_run = !(clk_stop_cfg &&
                            st_next.pstate == bpsr_pkg::BPSR_D3HOT); // R9
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            st_reg.pstate <= bpsr_pkg::STATE_RESET;
            st_reg.scratch <= bpsr_pkg::SCRATCH_RESET;
            st_reg.rdata <= 16'h0000;
            st_reg.rvalid <= 1'b0;
            st_reg.rev_code <= bpsr_pkg::REV_1_1;
            st_reg.clk_run <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_cfg_rdata = st_reg.rdata;
    assign o_cfg_rvalid = st_reg.rvalid;
    assign o_device_power_state_field = st_reg.pstate;
    assign o_wake_event_scratch_enable = st_reg.scratch;
    assign o_pm_revision_code = st_reg.rev_code;
    assign o_secondary_clock_run = st_reg.clk_run;
endmodule

// File: tb/bpsr_regs_monitor.sv
// Assertion checker for the power-state registers
`timescale 1ns/1ps
module bpsr_regs_monitor (
    input wire logic i_clk_sys, i_reset, i_cfg_wr, i_cfg_rd, o_cfg_rvalid,
    input wire logic o_wake_event_scratch_enable, o_secondary_clock_run,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [1:0] i_cfg_be, o_device_power_state_field,
    input wire logic [15:0] i_cfg_wdata, o_cfg_rdata,
    input wire logic [2:0] o_pm_revision_code
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    logic pw;
    assign pw = i_cfg_wr && i_cfg_addr == 8'h4C;
    a_state_write: assert property (pw && i_cfg_be[0] |=>
        o_device_power_state_field == $past(i_cfg_wdata[1:0])) else $error("state lost");
    a_scratch_write: assert property (pw && i_cfg_be[1] |=>
        o_wake_event_scratch_enable == $past(i_cfg_wdata[8])) else $error("scratch lost");
    a_state_hold: assert property (!pw |=> $stable(o_device_power_state_field)
        && $stable(o_wake_event_scratch_enable)) else $error("state moved");
    a_pcs_zero: assert property (o_cfg_rvalid && $past(i_cfg_addr) == 8'h4C
        |-> (o_cfg_rdata & 16'hFEF4) == 16'h0000) else $error("fixed bits set");
    a_kept_bit: assert property (o_cfg_rvalid && $past(i_cfg_addr) == 8'h4C
        |-> o_cfg_rdata[3] == o_pm_revision_code[0]) else $error("kept bit wrong");
    a_bse_fixed: assert property (o_cfg_rvalid && $past(i_cfg_addr) == 8'h4E
        |-> (o_cfg_rdata & 16'hFF7F) == 16'h0040) else $error("extension wrong");
    a_run_outside_d3: assert property (o_device_power_state_field != 2'h3
        |-> o_secondary_clock_run) else $error("clock stopped");
    a_read_answer: assert property (i_cfg_rd |=> o_cfg_rvalid) else $error("no answer");
    a_wake_kept: assert property ($past(o_device_power_state_field) == 2'h3
        && o_device_power_state_field == 2'h0 && $past(i_cfg_be) == 2'h1
        |-> $stable(o_wake_event_scratch_enable)) else $error("context lost");
    a_rev_code: assert property (o_pm_revision_code inside {3'h2, 3'h3})
        else $error("bad revision");
    a_rvalid_only: assert property (o_cfg_rvalid |-> $past(i_cfg_rd))
        else $error("answer without read");
    a_rdata_idle: assert property (!o_cfg_rvalid |-> o_cfg_rdata == 16'h0000)
        else $error("read data not idle");
    cover property (pw && i_cfg_wdata[1:0] == 2'h3);
    cover property (o_device_power_state_field == 2'h3 && !o_secondary_clock_run);
    cover property (o_cfg_rvalid && o_cfg_rdata[7]);
endmodule
bind bpsr_regs bpsr_regs_monitor u_mon (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .o_cfg_rvalid(o_cfg_rvalid),
    .o_wake_event_scratch_enable(o_wake_event_scratch_enable),
    .o_secondary_clock_run(o_secondary_clock_run), .i_cfg_addr(i_cfg_addr),
    .i_cfg_be(i_cfg_be), .o_device_power_state_field(o_device_power_state_field),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
    .o_pm_revision_code(o_pm_revision_code));

// File: tb/bpsr_regs_bench.sv
// Self-checking bench for the power-state registers
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module bpsr_regs_bench;
    logic i_clk_sys = 0, i_reset = 1, wr = 0, rd = 0, sel = 1, stp = 0, rv, sc, run;
    logic [7:0] addr = 0;
    logic [1:0] be = 0, st;
    logic [15:0] wd = 0, rdat;
    logic [2:0] rev;
    int failures = 0, checked = 0, cyc = 0;
    bpsr_regs dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cfg_wr(wr), .i_cfg_rd(rd),
        .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdat),
        .o_cfg_rvalid(rv), .i_pm_revision_select(sel), .i_secondary_clock_stop_config(stp),
        .o_device_power_state_field(st), .o_wake_event_scratch_enable(sc),
        .o_pm_revision_code(rev), .o_secondary_clock_run(run));
    initial forever #20 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (++cyc > 2000) begin
        failures++;
        finish_test();
    end
    task automatic wr16(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        @(posedge i_clk_sys) #1;
        wr = 1; addr = a; be = b; wd = d;
        @(posedge i_clk_sys) #1;
        wr = 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_clk_sys) #1;
        rd = 1; addr = a;
        @(posedge i_clk_sys) #1;
        rd = 0;
        `CHK(rv, 1'b1)
        `CHK(rdat, e)
    endtask
    task automatic settle();
        repeat (4) @(posedge i_clk_sys);
        #1;
    endtask
    task finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk_sys);
        #1 i_reset = 0;
        settle();
        rdc(8'h4C, 16'h0008);
        rdc(8'h4E, 16'h0040);
        rdc(8'h4A, 16'h0003);
        `CHK(rev, 3'h3)
        rdc(8'h60, 16'h0000);
        wr16(8'h4C, 2'h3, 16'hFFFF);
        rdc(8'h4C, 16'h010B);
        wr16(8'h4C, 2'h2, 16'h0003);
        rdc(8'h4C, 16'h000B);
        wr16(8'h4C, 2'h3, 16'h0100);
        for (int i = 0; i < 4; i++) begin
            wr16(8'h4C, 2'h1, 16'(i));
            `CHK(st, 2'(i))
            `CHK(run, 1'b1)
        end
        stp = 1;
        settle();
        `CHK(run, 1'b0)
        rdc(8'h4E, 16'h00C0);
        wr16(8'h4E, 2'h3, 16'h0000);
        rdc(8'h4E, 16'h00C0);
        wr16(8'h4C, 2'h1, 16'h0000);
        `CHK(sc, 1'b1)
        `CHK(run, 1'b1)
        sel = 0;
        settle();
        rdc(8'h4C, 16'h0100);
        `CHK(rev, 3'h2)
        // Mid-run reset from D3hot with scratch set
        wr16(8'h4C, 2'h3, 16'h0103);
        i_reset = 1;
        repeat (3) @(posedge i_clk_sys);
        #1 i_reset = 0;
        `CHK(st, 2'h0)
        `CHK(sc, 1'b0)
        `CHK(run, 1'b1)
        rdc(8'h4C, 16'h0000);
        finish_test();
    end
endmodule
